// ---- inc/fpd_pkg.sv ----
package fpd_pkg;
    localparam int unsigned FPD_CHANNELS = 8;
    localparam int unsigned FPD_CLK_MHZ = 50;
    // Wake-up and entry times in nanoseconds.
    localparam int unsigned FPD_AMP_WAKE_NS = 2000;
    localparam int unsigned FPD_CONV_WAKE_NS = 1000;
    localparam int unsigned FPD_ENTRY_MAX_NS = 1000;
    localparam int unsigned FPD_AMP_WAKE_CYC = (FPD_AMP_WAKE_NS * FPD_CLK_MHZ + 999) / 1000;
    localparam int unsigned FPD_CONV_WAKE_CYC = (FPD_CONV_WAKE_NS * FPD_CLK_MHZ + 999) / 1000;
    localparam int unsigned FPD_ENTRY_MAX_CYC = (FPD_ENTRY_MAX_NS * FPD_CLK_MHZ) / 1000;
    // Wake time is the larger of the fixed time and one percent of the sleep time.
    localparam int unsigned FPD_WAKE_PERCENT_DIV = 100;
    // A zero divisor leaves only the fixed wake time, with no stretch for long sleeps.
    localparam int unsigned FPD_NO_STRETCH = 0;
    localparam int unsigned FPD_CNT_W = 32;
    // Field positions of the reference-mode, test-route and summing-amplifier-off bits.
    localparam int unsigned FPD_R3_EXTREF_BIT = 15;
    localparam int unsigned FPD_R1_EXTREF_BIT = 13;
    localparam int unsigned FPD_R59_TEST_BIT = 9;
    localparam int unsigned FPD_R59_SUMOFF_BIT = 8;
    typedef enum logic [1:0] {
        FPD_AWAKE = 2'b00,
        FPD_ASLEEP = 2'b01,
        FPD_WAKING = 2'b10
    } fpd_wake_t;
endpackage : fpd_pkg

// ---- testbench/fpd_ctrl_model.sv ----
`timescale 1ns/1ps
// System controller: pins and bits change on the falling edge, away from sampling.
module fpd_ctrl_model (
    input wire logic i_clock,
    input wire logic [28:0] i_cmd,
    output logic [28:0] o_pins
);
    // The summing amplifier is never left powered down while the test route is asked for.
    always @(negedge i_clock) begin
        o_pins <= {i_cmd[28:13], i_cmd[12] & ~i_cmd[11], i_cmd[11:0]};
    end
endmodule : fpd_ctrl_model

// ---- testbench/fpd_power_ctrl_asserts.sv ----
`timescale 1ns/1ps
module fpd_power_ctrl_asserts
    import fpd_pkg::*;
#(
    parameter int unsigned N = FPD_CHANNELS
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_global_shutdown_pin,
    input wire logic i_amp_chain_sleep_pin,
    input wire logic i_converter_sleep_pin,
    input wire logic i_amp_chain_fast_sleep_bit,
    input wire logic i_amp_chain_full_off_bit,
    input wire logic i_converter_fast_sleep_bit,
    input wire logic i_converter_full_off_bit,
    input wire logic i_atten_gain_off_bit,
    input wire logic i_preamp_off_bit,
    input wire logic [N-1:0] i_converter_channel_off_mask,
    input wire logic [N-1:0] i_amp_channel_off_mask,
    input wire logic i_reg3_extref_bit,
    input wire logic i_reg1_extref_bit,
    input wire logic i_gain_stage_test_bit,
    input wire logic [N-1:0] o_preamp_off,
    input wire logic [N-1:0] o_attenuator_off,
    input wire logic [N-1:0] o_gain_stage_off,
    input wire logic [N-1:0] o_converter_off,
    input wire logic o_amp_chain_ready,
    input wire logic o_external_reference,
    input wire logic o_test_route_seven_eight
);
    logic rst_ff;
    logic amp_any;
    logic conv_any;
    // Outputs written under reset are not a function of the inputs, so skip one edge.
    always_ff @(posedge i_clock) rst_ff <= i_rst;
    assign amp_any = i_global_shutdown_pin | i_amp_chain_sleep_pin
        | i_amp_chain_fast_sleep_bit | i_amp_chain_full_off_bit;
    assign conv_any = i_global_shutdown_pin | i_converter_sleep_pin
        | i_converter_fast_sleep_bit | i_converter_full_off_bit;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    sequence s_ready_low;
        !o_amp_chain_ready;
    endsequence
    property p_pre;
        !rst_ff |-> o_preamp_off
            == $past({N{amp_any | i_preamp_off_bit}} | i_amp_channel_off_mask);
    endproperty
    property p_att;
        !rst_ff |-> o_attenuator_off
            == $past({N{amp_any | i_atten_gain_off_bit}} | i_amp_channel_off_mask);
    endproperty
    property p_gain;
        !rst_ff |-> o_gain_stage_off
            == $past({N{amp_any | i_atten_gain_off_bit}} | i_amp_channel_off_mask);
    endproperty
    property p_conv;
        !rst_ff |-> o_converter_off == $past({N{conv_any}} | i_converter_channel_off_mask);
    endproperty
    property p_drop;
        i_amp_chain_sleep_pin |-> ##[1:50] s_ready_low;
    endproperty
    property p_wake;
        $rose(o_amp_chain_ready) |-> !$past(i_amp_chain_sleep_pin, 95);
    endproperty
    property p_extref;
        !rst_ff |-> o_external_reference == $past(i_reg3_extref_bit & i_reg1_extref_bit);
    endproperty
    property p_route;
        !rst_ff |-> o_test_route_seven_eight == $past(i_gain_stage_test_bit);
    endproperty
    a_pre: assert property (p_pre) else $error("preamp off mismatch");
    a_att: assert property (p_att) else $error("attenuator off mismatch");
    a_gain: assert property (p_gain) else $error("gain stage off mismatch");
    a_conv: assert property (p_conv) else $error("converter off mismatch");
    a_drop: assert property (p_drop) else $error("ready not dropped");
    a_wake: assert property (p_wake) else $error("ready rose early");
    a_extref: assert property (p_extref) else $error("reference mode mismatch");
    a_route: assert property (p_route) else $error("test route mismatch");
endmodule : fpd_power_ctrl_asserts
bind fpd_power_ctrl fpd_power_ctrl_asserts #(.N(N)) i_fpd_power_ctrl_asserts(.i_clock, .i_rst,
    .i_global_shutdown_pin, .i_amp_chain_sleep_pin, .i_converter_sleep_pin,
    .i_amp_chain_fast_sleep_bit, .i_amp_chain_full_off_bit, .i_converter_fast_sleep_bit,
    .i_converter_full_off_bit, .i_atten_gain_off_bit, .i_preamp_off_bit,
    .i_converter_channel_off_mask, .i_amp_channel_off_mask, .i_reg3_extref_bit,
    .i_reg1_extref_bit, .i_gain_stage_test_bit, .o_preamp_off, .o_attenuator_off,
    .o_gain_stage_off, .o_converter_off, .o_amp_chain_ready, .o_external_reference,
    .o_test_route_seven_eight);

// ---- testbench/tb_fpd_power_ctrl.sv ----
`timescale 1ns/1ps
module tb_fpd_power_ctrl;
    import fpd_pkg::*;
    logic i_clock = 1'b0;
    logic i_rst = 1'b1;
    logic [28:0] cmd = '0;
    logic [28:0] p;
    logic [7:0] pre, att, gst, cnv;
    logic rof, sof, part, comp, ardy, crdy, ext, route, sum;
    int miscompares = 0;
    int checked = 0;
    always #10 i_clock = ~i_clock;
    fpd_ctrl_model i_fpd_ctrl_model(.i_clock(i_clock), .i_cmd(cmd), .o_pins(p));
    fpd_power_ctrl #(.N(8)) i_fpd_power_ctrl(.i_clock(i_clock), .i_rst(i_rst),
        .i_global_shutdown_pin(p[0]), .i_amp_chain_sleep_pin(p[1]), .i_converter_sleep_pin(p[2]),
        .i_amp_chain_fast_sleep_bit(p[3]), .i_amp_chain_full_off_bit(p[4]),
        .i_converter_fast_sleep_bit(p[5]), .i_converter_full_off_bit(p[6]),
        .i_atten_gain_off_bit(p[7]), .i_preamp_off_bit(p[8]), .i_reg3_extref_bit(p[9]),
        .i_reg1_extref_bit(p[10]), .i_gain_stage_test_bit(p[11]), .i_sum_amp_off_bit(p[12]),
        .i_converter_channel_off_mask(p[20:13]), .i_amp_channel_off_mask(p[28:21]),
        .o_preamp_off(pre), .o_attenuator_off(att), .o_gain_stage_off(gst),
        .o_converter_off(cnv), .o_reference_off(rof), .o_serial_clock_off(sof),
        .o_partial_power_down(part), .o_complete_power_down(comp), .o_amp_chain_ready(ardy),
        .o_converter_ready(crdy), .o_external_reference(ext),
        .o_test_route_seven_eight(route), .o_sum_amp_off(sum));
    task chk(input string nm, input logic [23:0] e, input logic [23:0] s);
        checked++;
        if (s !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task finish_test;
        if (miscompares == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test
    task step(input logic [28:0] c, input int n);
        @(posedge i_clock);
        cmd = c;
        repeat (n) @(posedge i_clock);
        #1;
    endtask : step
    function automatic logic [23:0] exp_off(input logic [28:0] c);
        logic a;
        a = c[0] | c[1] | c[3] | c[4];
        return {{8{a | c[8]}} | c[28:21], {8{a | c[7]}} | c[28:21],
            {8{c[0] | c[2] | c[5] | c[6]}} | c[20:13]};
    endfunction : exp_off
    task t_blocks;
        for (int k = 0; k < 29; k++) begin
            if (k < 9 || k > 12) begin
                step(29'h1 << k, 2);
                chk("blocks", exp_off(29'h1 << k), {pre, att, cnv});
                chk("gain_stage", exp_off(29'h1 << k) >> 8 & 24'h00ff, gst);
            end
        end
    endtask : t_blocks
    task t_or;
        step(29'h102, 2);
        step(29'h100, 2);
        chk("preamp_only", exp_off(29'h100), {pre, att, cnv});
        step(29'h003, 2);
        step(29'h002, 2);
        chk("pin_left", exp_off(29'h002), {pre, att, cnv});
    endtask : t_or
    task t_partial;
        step(29'h606, 2);
        chk("partial_pin", 24'h8, {part, comp, rof, sof});
        chk("ext_kept", 24'h1, ext);
        step(29'h628, 2);
        chk("partial_bit", 24'h8, {part, comp, rof, sof});
        step(29'h650, 2);
        chk("full_off", 24'h0000_07, {part, comp, rof, sof});
        chk("ext_full", 24'h1, ext);
        step(29'h001, 2);
        chk("global", 24'h0000_07, {part, comp, rof, sof});
    endtask : t_partial
    task t_modes;
        for (int k = 0; k < 4; k++) begin
            step(29'(k) << 9, 2);
            chk("ext_ref", 24'(k == 3), ext);
        end
        step(29'h1800, 2);
        chk("test_on", 24'h2, {route, sum});
        step(29'h1000, 2);
        chk("test_off", 24'h1, {route, sum});
    endtask : t_modes
    task t_wake(input int len, input int lo, input int hi);
        step(29'h006, len);
        chk("ready_drop", 24'h0, {ardy, crdy});
        step(29'h0, 45);
        chk("conv_wait", 24'h0, {ardy, crdy});
        repeat (15) @(posedge i_clock);
        chk("conv_awake", 24'h1, crdy);
        repeat (lo - 60) @(posedge i_clock);
        chk("amp_wait", 24'h0, ardy);
        repeat (hi - lo) @(posedge i_clock);
        chk("amp_awake", 24'h1, ardy);
    endtask : t_wake
    initial begin
        repeat (12) @(posedge i_clock);
        @(negedge i_clock) i_rst = 1'b0;
        chk("reset_ready", 24'h3, {ardy, crdy});
        chk("reset_off", 24'h0, {pre, att, cnv});
        t_blocks();
        t_or();
        t_partial();
        t_modes();
        step(29'h0, 300);
        t_wake(10, 95, 110);
        t_wake(20000, 190, 215);
        finish_test();
    end
    initial begin
        repeat (60000) @(posedge i_clock);
        miscompares++;
        finish_test();
    end
endmodule : tb_fpd_power_ctrl

// ---- verilog/fpd_or_reduce.sv ----
`timescale 1ns/1ps
// Per-channel power-down gate: a channel is off when any global source or its mask bit is set.
module fpd_or_reduce
    import fpd_pkg::*;
#(
    parameter int unsigned N = FPD_CHANNELS
) (
    input wire logic i_global,
    input wire logic [N-1:0] i_mask,
    output logic [N-1:0] o_off
);
    assign o_off = {N{i_global}} | i_mask;
endmodule : fpd_or_reduce

// ---- verilog/fpd_power_ctrl.sv ----
`timescale 1ns/1ps
module fpd_power_ctrl
    import fpd_pkg::*;
#(
    parameter int unsigned N = FPD_CHANNELS
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_global_shutdown_pin,
    input wire logic i_amp_chain_sleep_pin,
    input wire logic i_converter_sleep_pin,
    input wire logic i_amp_chain_fast_sleep_bit,
    input wire logic i_amp_chain_full_off_bit,
    input wire logic i_converter_fast_sleep_bit,
    input wire logic i_converter_full_off_bit,
    input wire logic i_atten_gain_off_bit,
    input wire logic i_preamp_off_bit,
    input wire logic [N-1:0] i_converter_channel_off_mask,
    input wire logic [N-1:0] i_amp_channel_off_mask,
    input wire logic i_reg3_extref_bit,
    input wire logic i_reg1_extref_bit,
    input wire logic i_gain_stage_test_bit,
    input wire logic i_sum_amp_off_bit,
    output logic [N-1:0] o_preamp_off,
    output logic [N-1:0] o_attenuator_off,
    output logic [N-1:0] o_gain_stage_off,
    output logic [N-1:0] o_converter_off,
    output logic o_reference_off,
    output logic o_serial_clock_off,
    output logic o_partial_power_down,
    output logic o_complete_power_down,
    output logic o_amp_chain_ready,
    output logic o_converter_ready,
    output logic o_external_reference,
    output logic o_test_route_seven_eight,
    output logic o_sum_amp_off
);
    typedef struct packed {
        logic [N-1:0] pre;
        logic [N-1:0] att;
        logic [N-1:0] gst;
        logic [N-1:0] conv;
        logic refoff;
        logic sclkoff;
        logic partial;
        logic complete;
        logic extref;
        logic route;
        logic sumoff;
    } fpd_pc_state_t;
    fpd_pc_state_t state_ff;
    fpd_pc_state_t nxt_state;
    logic amp_any;
    logic conv_any;
    logic amp_full;
    logic conv_full;
    logic [N-1:0] amp_ch;
    logic [N-1:0] conv_ch;
    logic amp_rdy;
    logic conv_rdy;

    // Full-off sources on both chains together drop references; fast-sleep sources leave them running.
    assign amp_full = i_global_shutdown_pin | i_amp_chain_full_off_bit;
    assign conv_full = i_global_shutdown_pin | i_converter_full_off_bit;
    assign amp_any = amp_full | i_amp_chain_sleep_pin | i_amp_chain_fast_sleep_bit;
    assign conv_any = conv_full | i_converter_sleep_pin
        | i_converter_fast_sleep_bit;

    fpd_or_reduce #(.N(N)) u_amp_or (
        .i_global(amp_any),
        .i_mask(i_amp_channel_off_mask),
        .o_off(amp_ch)
    );

    fpd_or_reduce #(.N(N)) u_conv_or (
        .i_global(conv_any),
        .i_mask(i_converter_channel_off_mask),
        .o_off(conv_ch)
    );

    always_comb begin
        nxt_state = state_ff;
        // One-cycle registered path keeps entry far below the 1 us limit.
        nxt_state.pre = amp_ch | {N{i_preamp_off_bit}};
        nxt_state.att = amp_ch | {N{i_atten_gain_off_bit}};
        nxt_state.gst = amp_ch | {N{i_atten_gain_off_bit}};
        nxt_state.conv = conv_ch;
        // References stay alive unless both chains have a full-off source set; serial clocks unless the converter has one.
        nxt_state.refoff = amp_full & conv_full;
        nxt_state.sclkoff = conv_full;
        nxt_state.complete = amp_full & conv_full;
        nxt_state.partial = amp_any & conv_any & ~(amp_full & conv_full);
        nxt_state.extref = i_reg3_extref_bit & i_reg1_extref_bit;
        nxt_state.route = i_gain_stage_test_bit;
        nxt_state.sumoff = i_sum_amp_off_bit;
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // The fixed wake time is a floor; longer sleeps stretch it in proportion.
    fpd_wake_timer #(.MIN_CYC(FPD_AMP_WAKE_CYC), .PCT_DIV(FPD_WAKE_PERCENT_DIV)) u_amp_wake (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_off(amp_any),
        .o_ready(amp_rdy)
    );

    // Assumes the sampling clock ran long enough before wake, as the controller must ensure.
    // The converter wake time is fixed; only the amp chain stretches with the sleep length.
    fpd_wake_timer #(.MIN_CYC(FPD_CONV_WAKE_CYC), .PCT_DIV(FPD_NO_STRETCH)) u_conv_wake (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_off(conv_any),
        .o_ready(conv_rdy)
    );

    assign o_preamp_off = state_ff.pre;
    assign o_attenuator_off = state_ff.att;
    assign o_gain_stage_off = state_ff.gst;
    assign o_converter_off = state_ff.conv;
    assign o_reference_off = state_ff.refoff;
    assign o_serial_clock_off = state_ff.sclkoff;
    assign o_partial_power_down = state_ff.partial;
    assign o_complete_power_down = state_ff.complete;
    assign o_amp_chain_ready = amp_rdy;
    assign o_converter_ready = conv_rdy;
    assign o_external_reference = state_ff.extref;
    assign o_test_route_seven_eight = state_ff.route;
    assign o_sum_amp_off = state_ff.sumoff;
endmodule : fpd_power_ctrl

// ---- verilog/fpd_wake_timer.sv ----
`timescale 1ns/1ps
// Tracks one sleep/wake cycle; ready rises once the wake time has elapsed.
module fpd_wake_timer
    import fpd_pkg::*;
#(
    parameter int unsigned MIN_CYC = FPD_AMP_WAKE_CYC,
    parameter int unsigned PCT_DIV = FPD_WAKE_PERCENT_DIV
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_off,
    output logic o_ready
);
    typedef struct packed {
        fpd_wake_t st;
        logic [FPD_CNT_W-1:0] sleep_cnt;
        logic [FPD_CNT_W-1:0] wake_cnt;
        logic [FPD_CNT_W-1:0] wake_need;
        logic rdy;
    } fpd_wt_state_t;
    fpd_wt_state_t state_ff;
    fpd_wt_state_t nxt_state;
    // A divisor of zero turns the proportional stretch off, so no division by zero is built.
    localparam bit STRETCH = (PCT_DIV != 0);
    localparam logic [FPD_CNT_W-1:0] MIN_V = FPD_CNT_W'(MIN_CYC);
    localparam logic [FPD_CNT_W-1:0] ONE_V = FPD_CNT_W'(1);
    localparam logic [FPD_CNT_W-1:0] DIV_V = STRETCH ? FPD_CNT_W'(PCT_DIV) : ONE_V;
    logic [FPD_CNT_W-1:0] pct;

    always_comb begin
        nxt_state = state_ff;
        pct = STRETCH ? state_ff.sleep_cnt / DIV_V : '0;
        case (state_ff.st)
            FPD_AWAKE: begin
                nxt_state.rdy = ~i_off;
                if (i_off) begin
                    nxt_state.st = FPD_ASLEEP;
                    nxt_state.sleep_cnt = ONE_V;
                end
            end
            FPD_ASLEEP: begin
                nxt_state.rdy = 1'b0;
                // Saturate so a very long sleep cannot wrap to a short wake time.
                if (state_ff.sleep_cnt != '1) begin
                    nxt_state.sleep_cnt = state_ff.sleep_cnt + ONE_V;
                end
                if (!i_off) begin
                    nxt_state.st = FPD_WAKING;
                    nxt_state.wake_cnt = '0;
                    nxt_state.wake_need = (pct > MIN_V) ? pct : MIN_V;
                end
            end
            FPD_WAKING: begin
                nxt_state.rdy = 1'b0;
                if (i_off) begin
                    nxt_state.st = FPD_ASLEEP;
                    nxt_state.sleep_cnt = ONE_V;
                end else if (state_ff.wake_cnt + ONE_V >= state_ff.wake_need) begin
                    nxt_state.st = FPD_AWAKE;
                    nxt_state.rdy = 1'b1;
                end else begin
                    nxt_state.wake_cnt = state_ff.wake_cnt + ONE_V;
                end
            end
            default: begin
                nxt_state.st = FPD_AWAKE;
                nxt_state.rdy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            state_ff <= '{st: FPD_AWAKE, sleep_cnt: '0, wake_cnt: '0, wake_need: '0, rdy: 1'b1};
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign o_ready = state_ff.rdy;
endmodule : fpd_wake_timer
